//--- core/wdt_pkg.sv
// constants, types and state layout for the watchdog time-out unit
package wdt_pkg;

    // low-power rc oscillator and base periods
    localparam int RC_FREQ_KHZ          = 32;
    localparam int BASE_PERIOD_SHORT_MS = 1;
    localparam int BASE_PERIOD_LONG_MS  = 4;
    localparam int PRE_SHORT_DIV        = RC_FREQ_KHZ * BASE_PERIOD_SHORT_MS;
    localparam int PRE_LONG_DIV         = RC_FREQ_KHZ * BASE_PERIOD_LONG_MS;

    // combined prescaler and postscaler count
    localparam int CNT_W = 22;
    localparam int LIM_W = 23;

    // register bus
    localparam int ADDR_W = 8;
    localparam int DATA_W = 16;
    localparam logic [ADDR_W-1:0] ADDR_RESET_CTRL = 8'h00;
    localparam logic [ADDR_W-1:0] ADDR_IRQ_STATUS = 8'h04;
    localparam logic [ADDR_W-1:0] ADDR_IRQ_MASK   = 8'h08;
    localparam logic [ADDR_W-1:0] ADDR_COUNT      = 8'h0c;

    // reset control register fields
    localparam int RC_SOFT_EN_BIT = 5;
    localparam int RC_TIMEOUT_BIT = 4;
    localparam int RC_SLEEP_BIT   = 3;
    localparam int RC_IDLE_BIT    = 2;

    // configuration word fields
    localparam int CFG_W          = 8;
    localparam int CFG_POST_LSB   = 0;
    localparam int CFG_POST_W     = 4;
    localparam int CFG_PRE_BIT    = 4;
    localparam int CFG_WINDOW_DISABLE_BIT = 6;
    localparam int CFG_EN_BIT     = 7;

    // interrupt status and mask fields
    localparam int ST_W          = 3;
    localparam int ST_TIMEOUT    = 0;
    localparam int ST_WINDOW     = 1;
    localparam int ST_WAKE       = 2;
    localparam logic [ST_W-1:0] MASK_RST = 3'h0;

    typedef enum logic [2:0] {
        MODE_RUN   = 3'b001,
        MODE_SLEEP = 3'b010,
        MODE_IDLE  = 3'b100
    } pwr_mode_t;

    typedef struct packed {
        logic [ADDR_W-1:0] addr;
        logic [DATA_W-1:0] wdata;
        logic              wr;
        logic              rd;
    } reg_req_t;

    typedef struct packed {
        logic clear_instr;
        logic power_save;
        logic save_idle;
        logic clock_switch_done;
        logic wake_other;
        logic device_reset;
    } core_evt_t;

    typedef struct packed {
        logic              rc_s1;
        logic              rc_s2;
        logic              rc_s3;
        logic              cfg_valid;
        logic [CFG_W-1:0]  cfg;
        pwr_mode_t         mode;
        logic              soft_en;
        logic              timeout_flag;
        logic              sleep_flag;
        logic              idle_flag;
        logic [CNT_W-1:0]  cnt;
        logic [ST_W-1:0]   status;
        logic [ST_W-1:0]   mask;
        logic [DATA_W-1:0] rdata;
        logic              wdt_reset;
        logic              wake;
    } wdt_state_t;

endpackage

//--- core/watchdog_timeout_unit.sv
// watchdog time-out unit: rc-clock counter, windowed clear, wake and reset
`timescale 1ns/10ps
module watchdog_timeout_unit
    import wdt_pkg::*;
(
    input  wire logic                         sys_clk_i,
    input  wire logic                         rst_i,
    input  wire logic                         rc_clk_i,
    input  wire logic [wdt_pkg::CFG_W-1:0]    watchdog_config_word_i,
    input  wire wdt_pkg::core_evt_t           core_evt_i,
    input  wire wdt_pkg::reg_req_t            reg_req_i,
    output logic      [wdt_pkg::DATA_W-1:0]   rd_data_o,
    output logic                              rc_enable_o,
    output logic                              wdt_reset_o,
    output logic                              wake_o,
    output logic                              sleep_active_o,
    output logic                              idle_active_o,
    output logic                              irq_o
);
    import wdt_pkg::*;

    wdt_state_t        q;
    wdt_state_t        d;
    logic              rc_edge;
    logic              cfg_en;
    logic              cfg_pre;
    logic              cfg_window_disable;
    logic [3:0]        cfg_post;
    logic              running;
    logic [LIM_W-1:0]  limit;
    logic              window_open;
    logic              timeout_hit;
    logic              in_run;
    logic              clear_ok;
    logic              early_clear;
    logic              exit_save;
    logic              clr_cnt;
    logic              count_step;
    logic              wr_rc;
    logic              rd_status;
    logic [ST_W-1:0]   st_set;

    always_comb begin
        rc_edge    = q.rc_s2 & ~q.rc_s3;
        cfg_en     = q.cfg[CFG_EN_BIT];
        cfg_pre    = q.cfg[CFG_PRE_BIT];
        cfg_window_disable = q.cfg[CFG_WINDOW_DISABLE_BIT];
        cfg_post   = q.cfg[CFG_POST_LSB +: CFG_POST_W];
        in_run     = (q.mode == MODE_RUN);
        // enable forced by config, else by software bit
        running    = q.cfg_valid & (cfg_en | q.soft_en);
        // one count range covers prescaler and postscaler
        limit      = (cfg_pre ? LIM_W'(PRE_LONG_DIV) : LIM_W'(PRE_SHORT_DIV)) << cfg_post;
        window_open = ({1'b0, q.cnt} >= (limit - (limit >> 2)));
        timeout_hit = running & rc_edge & ({1'b0, q.cnt} == (limit - LIM_W'(1)));
        clear_ok    = core_evt_i.clear_instr & in_run;
        early_clear = clear_ok & running & ~cfg_window_disable & ~window_open;
        exit_save   = ~in_run & (timeout_hit | core_evt_i.wake_other);
        clr_cnt     = core_evt_i.device_reset
                    | core_evt_i.clock_switch_done
                    | (core_evt_i.power_save & in_run)
                    | exit_save
                    | clear_ok
                    | timeout_hit
                    | ~running;
        count_step  = running & rc_edge & ~clr_cnt;
        wr_rc       = reg_req_i.wr & (reg_req_i.addr == ADDR_RESET_CTRL);
        rd_status   = reg_req_i.rd & (reg_req_i.addr == ADDR_IRQ_STATUS);
        st_set      = '0;
        st_set[ST_TIMEOUT] = timeout_hit;
        st_set[ST_WINDOW]  = early_clear;
        st_set[ST_WAKE]    = timeout_hit & ~in_run;

        d = q;
        // two-stage sync, third stage for edge detect
        d.rc_s1 = rc_clk_i;
        d.rc_s2 = q.rc_s1;
        d.rc_s3 = q.rc_s2;
        // config word caught in the first cycle after reset release
        if (!q.cfg_valid) begin
            d.cfg       = watchdog_config_word_i;
            d.cfg_valid = 1'b1;
        end

        // counter keeps running in every power mode
        if (clr_cnt) begin
            d.cnt = '0;
        end else if (count_step) begin
            d.cnt = q.cnt + CNT_W'(1);
        end

        d.wdt_reset = (timeout_hit & in_run) | early_clear;
        d.wake      = timeout_hit & ~in_run;

        case (q.mode)
            MODE_RUN: begin
                if (core_evt_i.power_save) begin
                    d.mode = core_evt_i.save_idle ? MODE_IDLE : MODE_SLEEP;
                end
            end
            MODE_SLEEP, MODE_IDLE: begin
                // resume after the power-save point, no reset
                if (exit_save) begin
                    d.mode = MODE_RUN;
                end
            end
            default: begin
                d.mode = MODE_RUN;
            end
        endcase

        // software writes, hardware sets win
        if (wr_rc) begin
            d.soft_en      = reg_req_i.wdata[RC_SOFT_EN_BIT];
            d.timeout_flag = reg_req_i.wdata[RC_TIMEOUT_BIT];
            d.sleep_flag   = reg_req_i.wdata[RC_SLEEP_BIT];
            d.idle_flag    = reg_req_i.wdata[RC_IDLE_BIT];
        end
        if (timeout_hit) begin
            d.timeout_flag = 1'b1;
        end
        if (core_evt_i.power_save & in_run) begin
            d.sleep_flag = ~core_evt_i.save_idle;
            d.idle_flag  = core_evt_i.save_idle;
        end
        if (core_evt_i.device_reset | d.wdt_reset) begin
            d.soft_en = 1'b0;
            d.mode    = MODE_RUN;
        end

        if (reg_req_i.wr & (reg_req_i.addr == ADDR_IRQ_MASK)) begin
            d.mask = reg_req_i.wdata[ST_W-1:0];
        end
        d.status = (rd_status ? '0 : q.status) | st_set;

        d.rdata = '0;
        if (reg_req_i.rd) begin
            if (reg_req_i.addr == ADDR_RESET_CTRL) begin
                d.rdata[RC_SOFT_EN_BIT] = q.soft_en;
                d.rdata[RC_TIMEOUT_BIT] = q.timeout_flag;
                d.rdata[RC_SLEEP_BIT]   = q.sleep_flag;
                d.rdata[RC_IDLE_BIT]    = q.idle_flag;
            end else if (reg_req_i.addr == ADDR_IRQ_STATUS) begin
                d.rdata[ST_W-1:0] = q.status;
            end else if (reg_req_i.addr == ADDR_IRQ_MASK) begin
                d.rdata[ST_W-1:0] = q.mask;
            end else if (reg_req_i.addr == ADDR_COUNT) begin
                d.rdata = q.cnt[CNT_W-1 -: DATA_W];
            end
        end
    end

    always_ff @(posedge sys_clk_i or posedge rst_i) begin
        if (rst_i) begin
            q              <= '0;
            q.mode         <= MODE_RUN;
            q.mask         <= MASK_RST;
        end else begin
            q <= d;
        end
    end

    assign rd_data_o      = q.rdata;
    assign rc_enable_o    = running;
    assign wdt_reset_o    = q.wdt_reset;
    assign wake_o         = q.wake;
    assign sleep_active_o = (q.mode == MODE_SLEEP);
    assign idle_active_o  = (q.mode == MODE_IDLE);
    assign irq_o          = |(q.status & q.mask);

    default clocking cb @(posedge sys_clk_i);
    endclocking
    default disable iff (rst_i);

    property p_en_forced;
        q.cfg_valid && cfg_en && !$past(rst_i) |-> rc_enable_o;
    endproperty
    a_en_forced: assert property (p_en_forced) else $error("forced enable lost");

    property p_soft_gate;
        q.cfg_valid && !cfg_en && !q.soft_en |-> !rc_enable_o && (count_step == 1'b0);
    endproperty
    a_soft_gate: assert property (p_soft_gate) else $error("runs without enable");

    property p_base_period;
        timeout_hit && cfg_post == 4'h0 |-> q.cnt == (cfg_pre ? 22'h00007f : 22'h00001f);
    endproperty
    a_base_period: assert property (p_base_period) else $error("bad base period");

    property p_post_max;
        timeout_hit && cfg_post == 4'hf && !cfg_pre |-> q.cnt == 22'h0fffff;
    endproperty
    a_post_max: assert property (p_post_max) else $error("bad postscale ratio");

    property p_reset_clears;
        core_evt_i.device_reset |=> q.cnt == 22'h000000 && !q.soft_en;
    endproperty
    a_reset_clears: assert property (p_reset_clears) else $error("reset left count");

    property p_switch_clears;
        core_evt_i.clock_switch_done |=> q.cnt == 22'h000000;
    endproperty
    a_switch_clears: assert property (p_switch_clears) else $error("switch left count");

    property p_save_clears;
        core_evt_i.power_save && in_run |=> q.cnt == 22'h000000 && q.mode != MODE_RUN;
    endproperty
    a_save_clears: assert property (p_save_clears) else $error("save entry failed");

    property p_exit_clears;
        core_evt_i.wake_other && !in_run |=> q.cnt == 22'h000000 && q.mode == MODE_RUN;
    endproperty
    a_exit_clears: assert property (p_exit_clears) else $error("save exit failed");

    property p_clear_instr;
        clear_ok && !early_clear |=> q.cnt == 22'h000000 ##1 !wdt_reset_o;
    endproperty
    a_clear_instr: assert property (p_clear_instr) else $error("clear did not clear");

    property p_count_sleep;
        !in_run && count_step |=> q.cnt == $past(q.cnt) + 22'h000001;
    endproperty
    a_count_sleep: assert property (p_count_sleep) else $error("no count in sleep");

    property p_wake;
        timeout_hit && !in_run |=> wake_o && !wdt_reset_o && q.mode == MODE_RUN;
    endproperty
    a_wake: assert property (p_wake) else $error("sleep time-out wrong");

    property p_flag_sticky;
        q.timeout_flag && !wr_rc |=> q.timeout_flag;
    endproperty
    a_flag_sticky: assert property (p_flag_sticky) else $error("flag lost");

    property p_early_clear;
        clear_ok && running && !cfg_window_disable && !window_open |=> wdt_reset_o ##1 !wdt_reset_o;
    endproperty
    a_early_clear: assert property (p_early_clear) else $error("early clear missed");

    property p_run_timeout;
        timeout_hit && in_run |=> wdt_reset_o && q.timeout_flag && !wake_o;
    endproperty
    a_run_timeout: assert property (p_run_timeout) else $error("run time-out wrong");

    property p_soft_clr;
        wdt_reset_o |-> !q.soft_en || $past(wr_rc);
    endproperty
    a_soft_clr: assert property (p_soft_clr) else $error("soft enable kept");

    property p_to_status;
        timeout_hit |=> q.status[ST_TIMEOUT];
    endproperty
    a_to_status: assert property (p_to_status) else $error("time-out status lost");

    property p_wake_status;
        timeout_hit && !in_run |=> q.status[ST_WAKE];
    endproperty
    a_wake_status: assert property (p_wake_status) else $error("wake status lost");

    property p_window_status;
        early_clear |=> q.status[ST_WINDOW];
    endproperty
    a_window_status: assert property (p_window_status) else $error("window status lost");

    property p_window_no_flag;
        early_clear && !timeout_hit && !q.timeout_flag && !wr_rc |=> !q.timeout_flag;
    endproperty
    a_window_no_flag: assert property (p_window_no_flag) else $error("window set flag");

    property p_window_disable_no_reset;
        clear_ok && cfg_window_disable && !timeout_hit |=> !wdt_reset_o;
    endproperty
    a_window_disable_no_reset: assert property (p_window_disable_no_reset) else $error("open clear reset");

    property p_late_clear_ok;
        clear_ok && window_open && !timeout_hit |=> !wdt_reset_o;
    endproperty
    a_late_clear_ok: assert property (p_late_clear_ok) else $error("late clear reset");

    property p_flag_set;
        timeout_hit |=> q.timeout_flag;
    endproperty
    a_flag_set: assert property (p_flag_set) else $error("flag not set");

    property p_flag_write_clr;
        wr_rc && !reg_req_i.wdata[RC_TIMEOUT_BIT] && !timeout_hit |=> !q.timeout_flag;
    endproperty
    a_flag_write_clr: assert property (p_flag_write_clr) else $error("flag not cleared");

    property p_soft_en_write;
        wr_rc && !core_evt_i.device_reset && !timeout_hit && !early_clear
            |=> q.soft_en == $past(reg_req_i.wdata[RC_SOFT_EN_BIT]);
    endproperty
    a_soft_en_write: assert property (p_soft_en_write) else $error("soft enable write");

    property p_dev_reset_mode;
        core_evt_i.device_reset |=> q.mode == MODE_RUN;
    endproperty
    a_dev_reset_mode: assert property (p_dev_reset_mode) else $error("reset left mode");

    property p_wdt_reset_mode;
        timeout_hit && in_run |=> q.mode == MODE_RUN && !q.soft_en;
    endproperty
    a_wdt_reset_mode: assert property (p_wdt_reset_mode) else $error("reset kept state");

    property p_save_flags;
        core_evt_i.power_save && in_run |=> q.sleep_flag != q.idle_flag;
    endproperty
    a_save_flags: assert property (p_save_flags) else $error("save flags wrong");

    property p_idle_entry;
        core_evt_i.power_save && core_evt_i.save_idle && in_run && !timeout_hit
            && !core_evt_i.device_reset && !early_clear |=> q.mode == MODE_IDLE;
    endproperty
    a_idle_entry: assert property (p_idle_entry) else $error("idle not entered");

    property p_clear_in_save;
        core_evt_i.clear_instr && !in_run |=> !wdt_reset_o;
    endproperty
    a_clear_in_save: assert property (p_clear_in_save) else $error("clear in save reset");

    property p_stop_holds;
        !running |=> q.cnt == 22'h000000;
    endproperty
    a_stop_holds: assert property (p_stop_holds) else $error("count while stopped");

    property p_count_step;
        count_step |=> q.cnt == $past(q.cnt) + 22'h000001;
    endproperty
    a_count_step: assert property (p_count_step) else $error("count step wrong");

    property p_count_hold;
        running && !rc_edge && !clr_cnt |=> $stable(q.cnt);
    endproperty
    a_count_hold: assert property (p_count_hold) else $error("count off rc edge");

    property p_wake_pulse;
        wake_o |=> !wake_o;
    endproperty
    a_wake_pulse: assert property (p_wake_pulse) else $error("wake too long");

    property p_wake_resume;
        wake_o |-> !sleep_active_o && !idle_active_o;
    endproperty
    a_wake_resume: assert property (p_wake_resume) else $error("wake without resume");

    property p_switch_no_reset;
        core_evt_i.clock_switch_done && !clear_ok && !timeout_hit |=> !wdt_reset_o;
    endproperty
    a_switch_no_reset: assert property (p_switch_no_reset) else $error("switch reset");

    property p_cfg_hold;
        q.cfg_valid |=> $stable(q.cfg);
    endproperty
    a_cfg_hold: assert property (p_cfg_hold) else $error("config changed");

    c_run_timeout: cover property (timeout_hit && in_run);
    c_sleep_wake:  cover property (timeout_hit && q.mode == MODE_SLEEP);
    c_idle_wake:   cover property (timeout_hit && q.mode == MODE_IDLE);
    c_early_clear: cover property (early_clear);
    c_irq:         cover property (irq_o);

endmodule

//--- test/core_model.sv
// partner model: rc oscillator and core instruction pulses
`timescale 1ns/10ps
module core_model (
    input  wire logic               sys_clk_i,
    input  wire logic               rc_enable_i,
    output logic                    rc_clk_o,
    output wdt_pkg::core_evt_t      core_evt_o
);
    import wdt_pkg::*;
    localparam int HALF = 2;
    int ph;
    initial begin
        rc_clk_o = 1'b0;
        core_evt_o = '0;
        ph = 0;
    end
    // oscillator runs only while the watchdog enables it
    always @(posedge sys_clk_i) begin
        if (rc_enable_i !== 1'b1) begin
            ph <= 0;
            rc_clk_o <= 1'b0;
        end else if (ph == HALF - 1) begin
            ph <= 0;
            rc_clk_o <= ~rc_clk_o;
        end else begin
            ph <= ph + 1;
        end
    end
    task automatic issue(input core_evt_t e);
        @(posedge sys_clk_i);
        core_evt_o <= e;
        @(posedge sys_clk_i);
        core_evt_o <= '0;
    endtask
endmodule

//--- test/testbench.sv
// self-checking bench for the watchdog time-out unit
`timescale 1ns/10ps
`define CHK(a, b) begin compares++; if ((a) !== (b)) begin fail_count++; \
    $display("unexpected at %0t: got %0h expected %0h", $time, a, b); end end
module testbench;
    import wdt_pkg::*;
    logic              sys_clk, rst, rc_en, rc_clk, wdt_rst, wake, sleep_a, idle_a, irq;
    logic [CFG_W-1:0]  cfg;
    reg_req_t          req;
    core_evt_t         evt;
    logic [DATA_W-1:0] rdata, v;
    int                fail_count, compares, n, rst_seen;
    logic              w;
    initial begin
        sys_clk = 1'b0;
        rst = 1'b1;
        cfg = 8'hc0;
        req = '0;
        fail_count = 0;
        compares = 0;
        rst_seen = 0;
    end
    always #2 sys_clk = ~sys_clk;
    always @(posedge sys_clk) if (wdt_rst === 1'b1) rst_seen++;
    watchdog_timeout_unit watchdog_timeout_unit_inst (
        .sys_clk_i(sys_clk), .rst_i(rst), .rc_clk_i(rc_clk),
        .watchdog_config_word_i(cfg), .core_evt_i(evt), .reg_req_i(req),
        .rd_data_o(rdata), .rc_enable_o(rc_en), .wdt_reset_o(wdt_rst), .wake_o(wake),
        .sleep_active_o(sleep_a), .idle_active_o(idle_a), .irq_o(irq));
    core_model core_model_inst (
        .sys_clk_i(sys_clk), .rc_enable_i(rc_en), .rc_clk_o(rc_clk), .core_evt_o(evt));
    task automatic end_of_test();
        $display("comparisons %0d, mismatches %0d", compares, fail_count);
        if (fail_count == 0 && compares > 0) begin
            $display("No errors found");
        end else begin
            $display("Errors were found");
        end
        $finish;
    endtask
    task automatic do_reset(input logic [CFG_W-1:0] c);
        @(posedge sys_clk);
        rst <= 1'b1;
        cfg <= c;
        repeat (6) @(posedge sys_clk);
        rst <= 1'b0;
    endtask
    task automatic wr(input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] d);
        @(posedge sys_clk);
        req <= '{addr: a, wdata: d, wr: 1'b1, rd: 1'b0};
        @(posedge sys_clk);
        req <= '0;
    endtask
    task automatic rd(input logic [ADDR_W-1:0] a, output logic [DATA_W-1:0] d);
        @(posedge sys_clk);
        req <= '{addr: a, wdata: '0, wr: 1'b0, rd: 1'b1};
        @(posedge sys_clk);
        req <= '0;
        #1 d = rdata;
    endtask
    task automatic rchk(input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] e);
        rd(a, v);
        `CHK(v, e)
    endtask
    // cycles until the next reset or wake pulse
    task automatic measure(input int lo, input int hi, input logic exp_wake);
        n = 0;
        w = 1'b0;
        while (w !== 1'b1 && n < 5000) begin
            @(posedge sys_clk);
            #1 n++;
            w = wdt_rst | wake;
        end
        `CHK(n >= lo && n <= hi, 1'b1)
        `CHK(wake, exp_wake)
    endtask
    initial begin
        do_reset(8'hc0);
        rchk(ADDR_RESET_CTRL, 16'h0000);
        rchk(ADDR_IRQ_MASK, 16'h0000);
        rchk(8'h10, 16'h0000);
        wr(ADDR_IRQ_MASK, 16'h0007);
        measure(118, 142, 1'b0);
        rchk(ADDR_RESET_CTRL, 16'h0010);
        `CHK(irq, 1'b1)
        rchk(ADDR_IRQ_STATUS, 16'h0001);
        `CHK(irq, 1'b0)
        wr(ADDR_RESET_CTRL, 16'h0000);
        rchk(ADDR_RESET_CTRL, 16'h0000);
        n = rst_seen;
        for (int k = 0; k < 6; k++) begin
            repeat (100) @(posedge sys_clk);
            core_model_inst.issue(core_evt_t'((k % 2) ? 6'h04 : 6'h20));
        end
        `CHK(rst_seen, n)
        core_model_inst.issue(core_evt_t'(6'h10));
        #1 `CHK(sleep_a, 1'b1)
        measure(118, 142, 1'b1);
        #1 `CHK(sleep_a, 1'b0)
        rchk(ADDR_RESET_CTRL, 16'h0018);
        rchk(ADDR_IRQ_STATUS, 16'h0005);
        wr(ADDR_RESET_CTRL, 16'h0000);
        rchk(ADDR_RESET_CTRL, 16'h0000);
        core_model_inst.issue(core_evt_t'(6'h18));
        #1 `CHK(idle_a, 1'b1)
        repeat (60) @(posedge sys_clk);
        core_model_inst.issue(core_evt_t'(6'h02));
        #1 `CHK(idle_a, 1'b0)
        measure(118, 142, 1'b0);
        do_reset(8'h40);
        repeat (3) @(posedge sys_clk);
        `CHK(rc_en, 1'b0)
        rchk(ADDR_COUNT, 16'h0000);
        wr(ADDR_RESET_CTRL, 16'h0020);
        #1 `CHK(rc_en, 1'b1)
        core_model_inst.issue(core_evt_t'(6'h01));
        #1 `CHK(rc_en, 1'b0)
        rchk(ADDR_RESET_CTRL, 16'h0000);
        do_reset(8'hd1);
        wr(ADDR_RESET_CTRL, 16'h0000);
        #1 `CHK(rc_en, 1'b1)
        measure(1000, 1040, 1'b0);
        do_reset(8'h80);
        repeat (20) @(posedge sys_clk);
        core_model_inst.issue(core_evt_t'(6'h20));
        #1 `CHK(wdt_rst, 1'b1)
        `CHK(wake, 1'b0)
        rchk(ADDR_IRQ_STATUS, 16'h0002);
        rchk(ADDR_RESET_CTRL, 16'h0000);
        do_reset(8'h80);
        repeat (112) @(posedge sys_clk);
        core_model_inst.issue(core_evt_t'(6'h20));
        measure(118, 142, 1'b0);
        rchk(ADDR_IRQ_STATUS, 16'h0001);
        end_of_test();
    end
    initial begin
        #100000;
        fail_count++;
        end_of_test();
    end
endmodule
